/* verif/sic_ctrl_model.sv */
`default_nettype none
module sic_ctrl_model (
    input wire logic clk,
    output var logic clk_en,
    output var logic chip_sel_n,
    output var logic row_strobe_n,
    output var logic col_strobe_n,
    output var logic write_en_n,
    output var logic [1:0] bank_addr,
    output var logic auto_pre
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {clk_en, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} = 5'h1F;
        {bank_addr, auto_pre} = 3'h0;
    end
    // one edge; caller keeps refresh to all-idle times, mode load is also sent with a bank active
    task automatic send(input logic [2:0] c, input logic [1:0] b, input logic ap,
            input logic ce, input logic cs);
        @(posedge clk);
        clk_en <= ce;
        chip_sel_n <= cs;
        {row_strobe_n, col_strobe_n, write_en_n} <= c;
        bank_addr <= b;
        auto_pre <= ap;
    endtask : send
    // nop or inhibit; unused address lines keep moving
    task automatic idle(input int n, input logic ce, input logic cs);
        repeat (n) send(sic_pkg::CMD_NOP, ~bank_addr, ~auto_pre, ce, cs);
    endtask : idle
endmodule : sic_ctrl_model
`default_nettype wire

/* verif/sic_top_monitor.sv */
`default_nettype none
module sic_top_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic chip_sel_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_en_n,
    input wire logic [1:0] bank_addr,
    input wire logic [2:0] bank_state0_ff,
    input wire logic [2:0] bank_state1_ff,
    input wire logic [2:0] bank_state2_ff,
    input wire logic [2:0] bank_state3_ff,
    input wire logic [2:0] pwr_state_ff,
    input wire logic all_idle_ff,
    input wire logic read_data_valid_ff,
    input wire logic write_data_take_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [2:0] cmd;
    assign cmd = chip_sel_n ? sic_pkg::CMD_NOP : {row_strobe_n, col_strobe_n, write_en_n};
    reset_vals_a: assert property (disable iff (1'b0) rst |=> all_idle_ff
        && pwr_state_ff == 3'h0 && bank_state0_ff == 3'h0) else $error("reset values");
    act_start_a: assert property (cmd == sic_pkg::CMD_ACTIVE && bank_addr == 2'h0
        && clk_en && $past(clk_en) && bank_state0_ff == 3'h0
        |-> ##[2:6] bank_state0_ff == 3'h1) else $error("active not taken");
    read_slot_a: assert property (cmd == sic_pkg::CMD_READ && clk_en && $past(clk_en)
        ##1 clk_en && cmd == sic_pkg::CMD_NOP |-> ##[2:9] read_data_valid_ff)
        else $error("read data missing");
    write_take_a: assert property (cmd == sic_pkg::CMD_WRITE && clk_en
        && $past(clk_en) |-> ##[2:7] write_data_take_ff) else $error("write data missing");
    pd_entry_a: assert property ($fell(clk_en) && chip_sel_n && all_idle_ff
        ##1 !clk_en [*3] |-> ##[0:4] pwr_state_ff == 3'h1) else $error("no power-down");
    sr_entry_a: assert property ($fell(clk_en) && cmd == sic_pkg::CMD_REFRESH
        && all_idle_ff ##1 !clk_en [*3] |-> ##[0:4] pwr_state_ff == 3'h2)
        else $error("no self refresh");
    sr_hold_a: assert property ((pwr_state_ff == 3'h2 && !clk_en) [*4]
        |=> pwr_state_ff == 3'h2) else $error("self refresh left early");
    pd_exit_a: assert property (pwr_state_ff == 3'h1 && $rose(clk_en) && chip_sel_n
        |-> ##[1:5] (pwr_state_ff == 3'h0 && all_idle_ff)) else $error("power-down stuck");
    sr_exit_a: assert property ($fell(pwr_state_ff == 3'h2) |-> pwr_state_ff == 3'h3
        ##[1:12] pwr_state_ff == 3'h0) else $error("self refresh exit wrong");
    suspend_hold_a: assert property (pwr_state_ff == 3'h4 ##1 pwr_state_ff == 3'h4
        |-> $stable({bank_state0_ff, bank_state1_ff, bank_state2_ff, bank_state3_ff}))
        else $error("bank moved in suspend");
    cover property (pwr_state_ff == 3'h4);
    cover property (pwr_state_ff == 3'h3);
    cover property (write_data_take_ff && bank_state1_ff == 3'h4);
endmodule : sic_top_monitor
bind sic_top sic_top_monitor mon (.*);
`default_nettype wire

/* verif/test_sdram_interbank_and_clk_en_control.sv */
`default_nettype none
module test_sdram_interbank_and_clk_en_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, auto_pre;
    logic [1:0] bank_addr, read_bank_ff, write_bank_ff;
    logic [2:0] bank_state0_ff, bank_state1_ff, bank_state2_ff, bank_state3_ff, pwr_state_ff;
    logic all_idle_ff, read_data_valid_ff, write_data_take_ff, illegal_ff;
    logic [2:0] bs [4];
    int n_fail = 0;
    int checks = 0;
    sic_ctrl_model ctl (.*);
    sic_top dut (.*);
    always_comb bs = '{bank_state0_ff, bank_state1_ff, bank_state2_ff, bank_state3_ff};
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] val(input int k);
        case (k)
            4: return 8'(pwr_state_ff);
            5: return 8'(read_data_valid_ff);
            6: return 8'(write_data_take_ff);
            7: return 8'(illegal_ff);
            default: return 8'(bs[k]);
        endcase
    endfunction : val
    task automatic wait_for(input int k, input logic [7:0] exp);
        for (int i = 0; i < 40 && val(k) !== exp; i++) @(negedge clk);
        chk(val(k), exp);
    endtask : wait_for
    task automatic finish_test();
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    task automatic t_inhibit();
        ctl.send(sic_pkg::CMD_ACTIVE, 2'h0, 1'b0, 1'b1, 1'b1);
        ctl.idle(6, 1'b1, 1'b0);
        chk(8'(bs[0]), 8'h0);
        chk(8'(all_idle_ff), 8'h1);
    endtask : t_inhibit
    task automatic t_pre_other();
        ctl.send(sic_pkg::CMD_ACTIVE, 2'h0, 1'b0, 1'b1, 1'b0);
        ctl.send(sic_pkg::CMD_ACTIVE, 2'h1, 1'b0, 1'b1, 1'b0);
        ctl.idle(1, 1'b1, 1'b0);
        wait_for(0, 8'h2);
        wait_for(1, 8'h2);
        ctl.send(sic_pkg::CMD_READ, 2'h0, 1'b0, 1'b1, 1'b0);
        ctl.idle(1, 1'b1, 1'b0);
        ctl.send(sic_pkg::CMD_PRECHARGE, 2'h1, 1'b0, 1'b1, 1'b0);
        ctl.idle(1, 1'b1, 1'b0);
        wait_for(1, 8'h6);
        chk(8'(bs[0]), 8'h3);
        wait_for(5, 8'h1);
        chk(8'(read_bank_ff), 8'h0);
    endtask : t_pre_other
    task automatic t_write_over_read();
        wait_for(1, 8'h0);
        wait_for(0, 8'h2);
        ctl.send(sic_pkg::CMD_ACTIVE, 2'h1, 1'b0, 1'b1, 1'b0);
        ctl.idle(1, 1'b1, 1'b0);
        wait_for(1, 8'h2);
        ctl.send(sic_pkg::CMD_READ, 2'h0, 1'b0, 1'b1, 1'b0);
        ctl.send(sic_pkg::CMD_WRITE, 2'h1, 1'b0, 1'b1, 1'b0);
        ctl.idle(1, 1'b1, 1'b0);
        wait_for(1, 8'h4);
        chk(8'(bs[0]), 8'h2);
        wait_for(6, 8'h1);
        chk(8'(write_bank_ff), 8'h1);
    endtask : t_write_over_read
    task automatic t_read_over_ap();
        wait_for(1, 8'h2);
        ctl.send(sic_pkg::CMD_READ, 2'h0, 1'b1, 1'b1, 1'b0);
        ctl.send(sic_pkg::CMD_READ, 2'h1, 1'b0, 1'b1, 1'b0);
        ctl.idle(1, 1'b1, 1'b0);
        wait_for(1, 8'h3);
        chk(8'(bs[0]), 8'h5);
        wait_for(0, 8'h0);
        ctl.send(sic_pkg::CMD_PRECHARGE, 2'h1, 1'b0, 1'b1, 1'b0);
        ctl.idle(1, 1'b1, 1'b0);
        wait_for(1, 8'h0);
    endtask : t_read_over_ap
    task automatic t_power();
        ctl.idle(8, 1'b0, 1'b1);
        wait_for(4, 8'h1);
        ctl.idle(3, 1'b1, 1'b1);
        wait_for(4, 8'h0);
        chk(8'(all_idle_ff), 8'h1);
        ctl.send(sic_pkg::CMD_REFRESH, 2'h0, 1'b0, 1'b0, 1'b0);
        ctl.idle(6, 1'b0, 1'b1);
        wait_for(4, 8'h2);
        ctl.idle(8, 1'b1, 1'b0);
        wait_for(4, 8'h0);
        chk(8'(all_idle_ff), 8'h1);
        ctl.send(sic_pkg::CMD_REFRESH, 2'h0, 1'b0, 1'b1, 1'b0);
        ctl.idle(1, 1'b1, 1'b0);
        wait_for(4, 8'h5);
        wait_for(4, 8'h0);
    endtask : t_power
    task automatic t_suspend();
        ctl.send(sic_pkg::CMD_ACTIVE, 2'h2, 1'b0, 1'b1, 1'b0);
        ctl.idle(1, 1'b1, 1'b0);
        wait_for(2, 8'h2);
        ctl.send(sic_pkg::CMD_READ, 2'h2, 1'b0, 1'b1, 1'b0);
        ctl.idle(6, 1'b0, 1'b0);
        wait_for(4, 8'h4);
        repeat (3) @(negedge clk);
        chk(8'(bs[2]), 8'h3);
        ctl.idle(1, 1'b1, 1'b0);
        wait_for(4, 8'h0);
        wait_for(2, 8'h2);
        ctl.send(sic_pkg::CMD_LOAD_MODE, 2'h0, 1'b0, 1'b1, 1'b0);
        ctl.idle(1, 1'b1, 1'b0);
        wait_for(7, 8'h1);
    endtask : t_suspend
    initial begin
        #60us;
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(8'(all_idle_ff), 8'h1);
        chk(8'(pwr_state_ff), 8'h0);
        chk(8'(bs[3]), 8'h0);
        t_inhibit();
        t_pre_other();
        t_write_over_read();
        t_read_over_ap();
        t_power();
        t_suspend();
        finish_test();
    end
endmodule : test_sdram_interbank_and_clk_en_control
`default_nettype wire

/* verilog/sic_bank.sv */
`default_nettype none
module sic_bank (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic cmd_act,
    input wire logic cmd_pre,
    input wire logic cmd_burst,
    input wire logic burst_write,
    input wire logic burst_auto_pre,
    input wire logic burst_done,
    input wire logic interrupt,
    input wire logic interrupt_by_write,
    output sic_pkg::sic_bank_state_t state,
    output logic auto_pre_flag
);
    sic_pkg::sic_bank_state_t state_ff;
    logic ap_ff;
    logic was_write_ff;
    logic [sic_pkg::TIMER_W-1:0] timer_ff;
    logic ap_pending_ff;

    assign state = state_ff;
    assign auto_pre_flag = ap_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= sic_pkg::BANK_IDLE;
            ap_ff <= 1'b0;
            was_write_ff <= 1'b0;
            timer_ff <= '0;
            ap_pending_ff <= 1'b0;
        end else if (run) begin
            if (timer_ff != '0) begin
                timer_ff <= timer_ff - 1'b1;
            end
            case (state_ff)
                sic_pkg::BANK_IDLE: begin
                    if (cmd_act) begin
                        state_ff <= sic_pkg::BANK_ACTIVATING;
                        timer_ff <= sic_pkg::TIMER_W'(sic_pkg::RCD_CYC - 1);
                    end
                end
                sic_pkg::BANK_ACTIVATING: begin
                    if (timer_ff == '0) begin
                        state_ff <= sic_pkg::BANK_ACTIVE;
                    end
                end
                sic_pkg::BANK_ACTIVE, sic_pkg::BANK_READING, sic_pkg::BANK_WRITING: begin
                    if (cmd_burst) begin
                        ap_ff <= burst_auto_pre;
                        was_write_ff <= burst_write;
                        state_ff <= burst_write ? sic_pkg::BANK_WRITING : sic_pkg::BANK_READING;
                    end else if (cmd_pre) begin
                        state_ff <= sic_pkg::BANK_PRECHARGING;
                        timer_ff <= sic_pkg::TIMER_W'(sic_pkg::PRECHARGE_CYC - 1);
                    end else if (interrupt || burst_done) begin
                        if (ap_ff) begin
                            // concurrent auto precharge, writes wait recovery first
                            state_ff <= sic_pkg::BANK_AUTO_PRE;
                            ap_pending_ff <= was_write_ff;
                            timer_ff <= was_write_ff ? sic_pkg::TIMER_W'(sic_pkg::WR_CYC - 1)
                                : sic_pkg::TIMER_W'(sic_pkg::PRECHARGE_CYC - 1);
                        end else begin
                            state_ff <= sic_pkg::BANK_ACTIVE;
                        end
                    end
                end
                sic_pkg::BANK_AUTO_PRE: begin
                    if (timer_ff == '0) begin
                        if (ap_pending_ff) begin
                            ap_pending_ff <= 1'b0;
                            timer_ff <= sic_pkg::TIMER_W'(sic_pkg::PRECHARGE_CYC - 1);
                        end else begin
                            state_ff <= sic_pkg::BANK_IDLE;
                            ap_ff <= 1'b0;
                        end
                    end
                end
                sic_pkg::BANK_PRECHARGING: begin
                    if (timer_ff == '0) begin
                        state_ff <= sic_pkg::BANK_IDLE;
                        ap_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= sic_pkg::BANK_IDLE;
                end
            endcase
        end
    end
endmodule : sic_bank
`default_nettype wire

/* verilog/sic_burst.sv */
`default_nettype none
module sic_burst (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic start,
    input wire logic stop,
    output logic active,
    output logic done
);
    logic [2:0] count_ff;

    assign active = (count_ff != 3'h0);
    assign done = run && (count_ff == 3'h1) && !start;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_ff <= 3'h0;
        end else if (run) begin
            if (start) begin
                count_ff <= 3'(sic_pkg::BURST_LEN);
            end else if (stop) begin
                count_ff <= 3'h0;
            end else if (count_ff != 3'h0) begin
                count_ff <= count_ff - 3'h1;
            end
        end
    end
endmodule : sic_burst
`default_nettype wire

/* verilog/sic_pkg.sv */
`default_nettype none
package sic_pkg;
    // command codes from {row_strobe_n, col_strobe_n, write_en_n}
    localparam logic [2:0] CMD_ACTIVE = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [2:0] CMD_BURST_STOP = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    localparam int NUM_BANKS = 4;
    localparam int CLK_PERIOD_NS = 20;
    localparam int PRECHARGE_TIME_NS = 20;
    localparam int ROW_TO_COLUMN_DELAY_NS = 20;
    localparam int WRITE_RECOVERY_TIME_NS = 15;
    localparam int SELF_REFRESH_EXIT_TIME_NS = 70;
    localparam int REFRESH_TIME_NS = 66;
    localparam int MODE_LOAD_CYCLES_NS = 40;
    localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RCD_CYC = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XSR_CYC = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RFC_CYC = (REFRESH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MRD_CYC = (MODE_LOAD_CYCLES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_LATENCY = 2;
    localparam int BURST_LEN = 4;
    localparam int TIMER_W = 4;

    typedef enum logic [2:0] {
        BANK_IDLE = 3'h0,
        BANK_ACTIVATING = 3'h1,
        BANK_ACTIVE = 3'h2,
        BANK_READING = 3'h3,
        BANK_WRITING = 3'h4,
        BANK_AUTO_PRE = 3'h5,
        BANK_PRECHARGING = 3'h6
    } sic_bank_state_t;

    typedef enum logic [2:0] {
        PWR_NORMAL = 3'h0,
        PWR_POWER_DOWN = 3'h1,
        PWR_SELF_REFRESH = 3'h2,
        PWR_SR_EXIT = 3'h3,
        PWR_SUSPEND = 3'h4,
        PWR_BUSY = 3'h5
    } sic_pwr_state_t;
endpackage : sic_pkg
`default_nettype wire

/* verilog/sic_top.sv */
// Operation
// - chip select high is inhibit; all strobes high is no-op; operations continue.
// - strobe patterns decode to active, read, write and precharge.
// - inter-bank rules apply only with clock enable high twice and exit time met.
// - idle bank n never restricts commands to another bank.
// - activating, active or precharging bank n allows all commands to other banks; refresh and mode load are flagged illegal unless all banks idle.
// - burst terminate acts on the current burst bank only.
// - precharge to bank m leaves bank n burst running.
// - interrupted auto-precharge burst starts its own precharge.
// - read interrupting read: new data replaces old after read latency.
// - write interrupting read ends the read at registration.
// - read interrupting write stops write at registration; data after read latency.
// - write interrupting write switches bank at registration.
// - read over read with auto precharge: precharge starts at registration.
// - write over read with auto precharge: read ends, precharge starts.
// - read over write with auto precharge: precharge after write recovery.
// - write over write with auto precharge: precharge after write recovery.
// - clock enable transitions enter power-down, self refresh or clock suspend.
// - power-down exits on clock enable high with inhibit or no-op.
// - self refresh exits with no-ops until exit time passes.
// - clock suspend exit resumes operation; next command at following edge.
`default_nettype none
module sic_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic chip_sel_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_en_n,
    input wire logic [1:0] bank_addr,
    input wire logic auto_pre,
    output logic [2:0] bank_state0_ff,
    output logic [2:0] bank_state1_ff,
    output logic [2:0] bank_state2_ff,
    output logic [2:0] bank_state3_ff,
    output logic [2:0] pwr_state_ff,
    output logic all_idle_ff,
    output logic read_data_valid_ff,
    output logic [1:0] read_bank_ff,
    output logic write_data_take_ff,
    output logic [1:0] write_bank_ff,
    output logic illegal_ff
);
    localparam int NB = sic_pkg::NUM_BANKS;

    // pin synchronisers
    logic [4:0] pin_s1_ff;
    logic [4:0] pin_s2_ff;
    logic [2:0] addr_s1_ff;
    logic [2:0] addr_s2_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_ff <= 5'h1F;
            pin_s2_ff <= 5'h1F;
            addr_s1_ff <= 3'h0;
            addr_s2_ff <= 3'h0;
        end else begin
            pin_s1_ff <= {clk_en, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n};
            pin_s2_ff <= pin_s1_ff;
            addr_s1_ff <= {bank_addr, auto_pre};
            addr_s2_ff <= addr_s1_ff;
        end
    end

    logic cke_now;
    logic cke_prev_ff;
    logic [2:0] cmd;
    logic [1:0] ba;
    logic ap;
    assign cke_now = pin_s2_ff[4];
    assign ba = addr_s2_ff[2:1];
    assign ap = addr_s2_ff[0];
    assign cmd = pin_s2_ff[3] ? sic_pkg::CMD_NOP : pin_s2_ff[2:0];
    // inhibit does not count as a no-op for the self refresh exit
    logic real_nop;
    assign real_nop = !pin_s2_ff[3] && (pin_s2_ff[2:0] == sic_pkg::CMD_NOP);

    always_ff @(posedge clk) begin
        if (rst) begin
            cke_prev_ff <= 1'b1;
        end else begin
            cke_prev_ff <= cke_now;
        end
    end

    function automatic logic is_nop(input logic [2:0] c);
        is_nop = (c == sic_pkg::CMD_NOP);
    endfunction : is_nop

    sic_pkg::sic_pwr_state_t pwr_ff;
    logic [sic_pkg::TIMER_W-1:0] pwr_timer_ff;
    logic [1:0] exit_nops_ff;
    logic run;
    logic any_burst;
    logic banks_idle;
    sic_pkg::sic_bank_state_t bstate [NB];

    // commands take effect only with enable held high and not in a low power state
    assign run = cke_prev_ff && cke_now && (pwr_ff == sic_pkg::PWR_NORMAL);

    always_comb begin
        banks_idle = 1'b1;
        for (int i = 0; i < NB; i++) begin
            if (bstate[i] != sic_pkg::BANK_IDLE) begin
                banks_idle = 1'b0;
            end
        end
    end

    // commands that reach the banks
    logic cmd_act;
    logic cmd_pre;
    logic cmd_burst;
    logic cmd_wr;
    logic cmd_stop;
    logic pre_all;

    assign cmd_act = run && (cmd == sic_pkg::CMD_ACTIVE);
    assign cmd_pre = run && (cmd == sic_pkg::CMD_PRECHARGE);
    assign pre_all = ap;
    assign cmd_burst = run && ((cmd == sic_pkg::CMD_READ) || (cmd == sic_pkg::CMD_WRITE));
    assign cmd_wr = (cmd == sic_pkg::CMD_WRITE);
    assign cmd_stop = run && (cmd == sic_pkg::CMD_BURST_STOP);

    // bank owning the current burst
    logic [1:0] cur_bank_ff;
    logic burst_done;
    logic burst_active;

    always_ff @(posedge clk) begin
        if (rst) begin
            cur_bank_ff <= 2'h0;
        end else if (cmd_burst) begin
            cur_bank_ff <= ba;
        end
    end

    sic_burst u_burst (
        .clk(clk),
        .rst(rst),
        .run(run),
        .start(cmd_burst),
        .stop(cmd_stop),
        .active(burst_active),
        .done(burst_done)
    );

    assign any_burst = burst_active;

    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_bank
            logic sel;
            logic own_burst;
            logic intr;
            assign sel = (ba == 2'(g));
            assign own_burst = burst_active && (cur_bank_ff == 2'(g));
            // another bank's burst ends this one; precharge elsewhere does not
            assign intr = own_burst && ((cmd_burst && !sel) || cmd_stop);
            sic_bank u_bank (
                .clk(clk),
                .rst(rst),
                .run(run),
                .cmd_act(cmd_act && sel),
                .cmd_pre(cmd_pre && (sel || pre_all)),
                .cmd_burst(cmd_burst && sel),
                .burst_write(cmd_wr),
                .burst_auto_pre(ap),
                .burst_done(burst_done && own_burst),
                .interrupt(intr),
                .interrupt_by_write(cmd_wr),
                .state(bstate[g]),
                .auto_pre_flag()
            );
        end
    endgenerate

    // read data pipeline: new read replaces old after latency
    logic [sic_pkg::READ_LATENCY-1:0] rd_pipe_ff;
    logic [1:0] rd_bank_pipe_ff [sic_pkg::READ_LATENCY];
    logic rd_now;
    logic cmd_wr_ff;
    assign rd_now = burst_active && !cmd_wr_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_wr_ff <= 1'b0;
        end else if (cmd_burst) begin
            cmd_wr_ff <= cmd_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_pipe_ff <= '0;
            for (int i = 0; i < sic_pkg::READ_LATENCY; i++) begin
                rd_bank_pipe_ff[i] <= 2'h0;
            end
        end else if (cke_now || pwr_ff != sic_pkg::PWR_SUSPEND) begin
            // write registration ends a read at once
            rd_pipe_ff[0] <= rd_now && !(cmd_burst && cmd_wr);
            rd_bank_pipe_ff[0] <= cur_bank_ff;
            for (int i = 1; i < sic_pkg::READ_LATENCY; i++) begin
                rd_pipe_ff[i] <= rd_pipe_ff[i-1];
                rd_bank_pipe_ff[i] <= rd_bank_pipe_ff[i-1];
            end
        end
    end

    // power state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_ff <= sic_pkg::PWR_NORMAL;
            pwr_timer_ff <= '0;
            exit_nops_ff <= 2'h0;
        end else begin
            case (pwr_ff)
                sic_pkg::PWR_NORMAL: begin
                    if (cke_prev_ff && !cke_now) begin
                        if (banks_idle && is_nop(cmd)) begin
                            pwr_ff <= sic_pkg::PWR_POWER_DOWN;
                        end else if (banks_idle && cmd == sic_pkg::CMD_REFRESH) begin
                            pwr_ff <= sic_pkg::PWR_SELF_REFRESH;
                        end else if (any_burst) begin
                            pwr_ff <= sic_pkg::PWR_SUSPEND;
                        end
                    end else if (run && banks_idle && cmd == sic_pkg::CMD_REFRESH) begin
                        pwr_ff <= sic_pkg::PWR_BUSY;
                        pwr_timer_ff <= sic_pkg::TIMER_W'(sic_pkg::RFC_CYC - 1);
                    end else if (run && banks_idle && cmd == sic_pkg::CMD_LOAD_MODE) begin
                        pwr_ff <= sic_pkg::PWR_BUSY;
                        pwr_timer_ff <= sic_pkg::TIMER_W'(sic_pkg::MRD_CYC - 1);
                    end
                end
                sic_pkg::PWR_BUSY: begin
                    if (pwr_timer_ff == '0) begin
                        pwr_ff <= sic_pkg::PWR_NORMAL;
                    end else begin
                        pwr_timer_ff <= pwr_timer_ff - 1'b1;
                    end
                end
                sic_pkg::PWR_POWER_DOWN: begin
                    if (cke_now && is_nop(cmd)) begin
                        pwr_ff <= sic_pkg::PWR_NORMAL;
                    end
                end
                sic_pkg::PWR_SELF_REFRESH: begin
                    if (cke_now && is_nop(cmd)) begin
                        pwr_ff <= sic_pkg::PWR_SR_EXIT;
                        pwr_timer_ff <= sic_pkg::TIMER_W'(sic_pkg::XSR_CYC - 1);
                        exit_nops_ff <= 2'h0;
                    end
                end
                sic_pkg::PWR_SR_EXIT: begin
                    if (real_nop && exit_nops_ff != 2'h2) begin
                        exit_nops_ff <= exit_nops_ff + 2'h1;
                    end
                    if (pwr_timer_ff != '0) begin
                        pwr_timer_ff <= pwr_timer_ff - 1'b1;
                    end else if (exit_nops_ff == 2'h2) begin
                        pwr_ff <= sic_pkg::PWR_NORMAL;
                    end
                end
                sic_pkg::PWR_SUSPEND: begin
                    if (cke_now) begin
                        pwr_ff <= sic_pkg::PWR_NORMAL;
                    end
                end
                default: begin
                    pwr_ff <= sic_pkg::PWR_NORMAL;
                end
            endcase
        end
    end

    // unsupported combinations flagged for the controller side
    logic bad;

    always_comb begin
        bad = 1'b0;
        if (run && !is_nop(cmd)) begin
            if ((cmd == sic_pkg::CMD_REFRESH || cmd == sic_pkg::CMD_LOAD_MODE) && !banks_idle) begin
                bad = 1'b1;
            end
            if (cmd == sic_pkg::CMD_BURST_STOP && !burst_active) begin
                bad = 1'b1;
            end
            if (cmd == sic_pkg::CMD_ACTIVE && bstate[ba] != sic_pkg::BANK_IDLE) begin
                bad = 1'b1;
            end
            if (cmd_burst && bstate[ba] != sic_pkg::BANK_ACTIVE
                && bstate[ba] != sic_pkg::BANK_READING
                && bstate[ba] != sic_pkg::BANK_WRITING) begin
                bad = 1'b1;
            end
        end
        if (pwr_ff == sic_pkg::PWR_SR_EXIT && !is_nop(cmd)) begin
            bad = 1'b1;
        end
        // refresh and mode load accept no command until done
        if (pwr_ff == sic_pkg::PWR_BUSY && !is_nop(cmd)) begin
            bad = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bank_state0_ff <= 3'h0;
            bank_state1_ff <= 3'h0;
            bank_state2_ff <= 3'h0;
            bank_state3_ff <= 3'h0;
            pwr_state_ff <= 3'h0;
            all_idle_ff <= 1'b1;
            read_data_valid_ff <= 1'b0;
            read_bank_ff <= 2'h0;
            write_data_take_ff <= 1'b0;
            write_bank_ff <= 2'h0;
            illegal_ff <= 1'b0;
        end else begin
            bank_state0_ff <= bstate[0];
            bank_state1_ff <= bstate[1];
            bank_state2_ff <= bstate[2];
            bank_state3_ff <= bstate[3];
            pwr_state_ff <= pwr_ff;
            all_idle_ff <= banks_idle && (pwr_ff == sic_pkg::PWR_NORMAL);
            read_data_valid_ff <= rd_pipe_ff[sic_pkg::READ_LATENCY-1];
            read_bank_ff <= rd_bank_pipe_ff[sic_pkg::READ_LATENCY-1];
            // write data taken on the command edge; interruption switches bank
            write_data_take_ff <= run && ((cmd_burst && cmd_wr)
                || (burst_active && cmd_wr_ff && !cmd_burst));
            write_bank_ff <= cmd_burst ? ba : cur_bank_ff;
            illegal_ff <= bad;
        end
    end
endmodule : sic_top
`default_nettype wire
